// ==== logic/tmau_pkg.sv ====
// tmau_pkg: addresses, field layout, reset values and pin actions
// assumes: 32-bit byte-addressed register port, single timer clock
package tmau_pkg;
  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int unsigned TMAU_NCH = 4;
  localparam int unsigned TMAU_DW = 32;
  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] TMAU_A_RUN = 32'hE004_1000;
  localparam logic [31:0] TMAU_A_COUNT = 32'hE004_1004;
  localparam logic [31:0] TMAU_A_LIMIT = 32'hE004_1008;
  localparam logic [31:0] TMAU_A_MAC = 32'hE004_100C;
  localparam logic [31:0] TMAU_A_EMC = 32'hE004_1010;
  localparam logic [31:0] TMAU_A_CMP = 32'hE004_1014;
  localparam logic [31:0] TMAU_A_STEP = 32'h0000_0004;
  localparam logic [31:0] TMAU_A_INT_ST = 32'hE004_1030;
  localparam logic [31:0] TMAU_A_INT_MSK = 32'hE004_1034;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned TMAU_RUN_POS = 0;
  localparam int unsigned TMAU_HOLD_POS = 1;
  localparam int unsigned TMAU_CLR_POS = 0;
  localparam int unsigned TMAU_HALT_POS = 1;
  localparam int unsigned TMAU_MAC_STEP = 2;
  localparam int unsigned TMAU_MAC_W = 8;
  localparam int unsigned TMAU_ACT_LSB = 4;
  localparam int unsigned TMAU_ACT_FW = 2;
  localparam int unsigned TMAU_ACT_W = 8;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] TMAU_MAC_RST = 8'h00;
  localparam logic [7:0] TMAU_ACT_RST = 8'h00;
  localparam logic [31:0] TMAU_WORD_RST = 32'h0000_0000;
  localparam logic [3:0] TMAU_CH_RST = 4'h0;
  // pin action encoding
  typedef enum logic [1:0] {
    TMAU_PIN_KEEP = 2'h0,
    TMAU_PIN_LOW = 2'h1,
    TMAU_PIN_HIGH = 2'h2,
    TMAU_PIN_TOGGLE = 2'h3
  } tmau_pin_act_t;
  // new pin level for an action, used on match and on software write
  function automatic logic tmau_apply_act(input logic [1:0] act, input logic cur);
    case (act)
      TMAU_PIN_LOW: tmau_apply_act = 1'b0;
      TMAU_PIN_HIGH: tmau_apply_act = 1'b1;
      TMAU_PIN_TOGGLE: tmau_apply_act = ~cur;
      default: tmau_apply_act = cur;
    endcase
  endfunction : tmau_apply_act
endpackage : tmau_pkg

// ==== logic/tmau_counter.sv ====
// tmau_counter: prescale counter and timer count
// assumes: synchronous reset copy from the top, one clock
module tmau_counter (
  input logic clk,
  input logic rst_n,
  input logic run,
  input logic hold,
  input logic [31:0] limit,
  input logic clear,
  input logic load,
  input logic [31:0] load_val,
  output logic [31:0] count,
  output logic [31:0] presc
);
  logic [31:0] count_q;
  logic [31:0] presc_q;
  // hold beats clear beats software load beats counting
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= tmau_pkg::TMAU_WORD_RST;
      presc_q <= tmau_pkg::TMAU_WORD_RST;
    end else if (hold || clear) begin
      count_q <= tmau_pkg::TMAU_WORD_RST;
      presc_q <= tmau_pkg::TMAU_WORD_RST;
    end else if (load) begin
      count_q <= load_val;
    end else if (run) begin
      if (presc_q == limit) begin
        presc_q <= tmau_pkg::TMAU_WORD_RST;
        count_q <= count_q + 32'h0000_0001;
      end else begin
        presc_q <= presc_q + 32'h0000_0001;
      end
    end
  end
  assign count = count_q;
  assign presc = presc_q;
endmodule : tmau_counter

// ==== logic/tmau_match_chan.sv ====
// tmau_match_chan: one compare channel with its match pin
// assumes: count and compare come from flops in the same clock
module tmau_match_chan (
  input logic clk,
  input logic rst_n,
  input logic [31:0] count,
  input logic [31:0] compare,
  input logic [1:0] act,
  input logic act_wr,
  input logic [1:0] act_new,
  output logic evt,
  output logic level
);
  logic eq;
  logic eq_q;
  logic level_q;
  // equality is edge-detected so a held count fires once
  assign eq = (count == compare);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      eq_q <= 1'b1; // no spurious event right after reset
    end else begin
      eq_q <= eq;
    end
  end
  assign evt = eq & ~eq_q;
  // a write defines the level at once and takes priority over a match
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level_q <= 1'b0;
    end else if (act_wr) begin
      level_q <= tmau_pkg::tmau_apply_act(act_new, level_q);
    end else if (evt) begin
      level_q <= tmau_pkg::tmau_apply_act(act, level_q);
    end
  end
  assign level = level_q;
endmodule : tmau_match_chan

// ==== logic/tmau_top.sv ====
// tmau_top: match-action timer with register port and interrupt
// assumes: master keeps strobes one cycle, never both at once
//
// Our own choice: strobed register access.
module tmau_top (
  input logic core_clk,
  input logic rst_n,
  input logic [31:0] reg_addr,
  input logic [31:0] reg_wdata,
  input logic reg_wr,
  input logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic [3:0] match_pin_out,
  output logic irq
);
  localparam int unsigned NCH = tmau_pkg::TMAU_NCH;
  localparam int unsigned FW = tmau_pkg::TMAU_ACT_FW;
  localparam int unsigned STP = tmau_pkg::TMAU_MAC_STEP;

  // ------------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic rst_core_n;
  // asynchronous assert, release through two flops
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_core_n = rst_sync_q[1];

  // ------------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------------
  // one-hot compare register select, used by write and read paths
  function automatic logic [NCH-1:0] cmp_sel(input logic [31:0] a);
    logic [NCH-1:0] s;
    s = '0;
    for (int k = 0; k < NCH; k++) begin
      s[k] = (a == tmau_pkg::TMAU_A_CMP + 32'(k) * tmau_pkg::TMAU_A_STEP);
    end
    cmp_sel = s;
  endfunction : cmp_sel

  logic wr_run;
  logic wr_count;
  logic wr_limit;
  logic wr_mac;
  logic wr_emc;
  logic wr_st;
  logic wr_msk;
  logic [NCH-1:0] wr_cmp;
  // write strobes per register
  // full 32-bit compare, so aliases of a register never hit it
  assign wr_run = reg_wr && (reg_addr == tmau_pkg::TMAU_A_RUN);
  assign wr_count = reg_wr && (reg_addr == tmau_pkg::TMAU_A_COUNT);
  assign wr_limit = reg_wr && (reg_addr == tmau_pkg::TMAU_A_LIMIT);
  assign wr_mac = reg_wr && (reg_addr == tmau_pkg::TMAU_A_MAC);
  assign wr_emc = reg_wr && (reg_addr == tmau_pkg::TMAU_A_EMC);
  assign wr_st = reg_wr && (reg_addr == tmau_pkg::TMAU_A_INT_ST);
  assign wr_msk = reg_wr && (reg_addr == tmau_pkg::TMAU_A_INT_MSK);
  assign wr_cmp = reg_wr ? cmp_sel(reg_addr) : '0;

  // ------------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------------
  logic run_q;
  logic hold_q;
  logic [31:0] limit_q;
  logic [7:0] mac_q;
  logic [7:0] act_q;
  logic [31:0] cmp_q [NCH];
  logic [NCH-1:0] evt;
  logic [NCH-1:0] halt_en;
  logic [NCH-1:0] clr_en;
  logic [NCH-1:0] pin_q;
  logic halt_now;
  logic clear_now;
  logic run_eff;
  logic [31:0] count_value;
  logic [31:0] presc_q;

  // run and hold bits; a halting match drops run and beats the write
  always_ff @(posedge core_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      run_q <= 1'b0;
      hold_q <= 1'b0;
    end else begin
      if (wr_run) begin
        run_q <= reg_wdata[tmau_pkg::TMAU_RUN_POS];
        hold_q <= reg_wdata[tmau_pkg::TMAU_HOLD_POS];
      end
      if (halt_now) begin
        run_q <= 1'b0;
      end
    end
  end

  // divider limit only changes while stopped, avoids a torn period
  always_ff @(posedge core_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      limit_q <= tmau_pkg::TMAU_WORD_RST;
    end else if (wr_limit && !run_q) begin
      limit_q <= reg_wdata;
    end
  end

  // match action control, upper bits never stored
  always_ff @(posedge core_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      mac_q <= tmau_pkg::TMAU_MAC_RST;
    end else if (wr_mac) begin
      mac_q <= reg_wdata[tmau_pkg::TMAU_MAC_W-1:0];
    end
  end

  // external match control action fields
  always_ff @(posedge core_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      act_q <= tmau_pkg::TMAU_ACT_RST;
    end else if (wr_emc) begin
      act_q <= reg_wdata[tmau_pkg::TMAU_ACT_LSB +: tmau_pkg::TMAU_ACT_W];
    end
  end

  // ------------------------------------------------------------------
  // channels
  // ------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < NCH; i++) begin : g_ch
      // compare value per channel
      always_ff @(posedge core_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
          cmp_q[i] <= tmau_pkg::TMAU_WORD_RST;
        end else if (wr_cmp[i]) begin
          cmp_q[i] <= reg_wdata;
        end
      end
      assign halt_en[i] = mac_q[STP*i + tmau_pkg::TMAU_HALT_POS];
      assign clr_en[i] = mac_q[STP*i + tmau_pkg::TMAU_CLR_POS];
      // edge detect sits in the channel so each pin keeps its own history
      tmau_match_chan u_ch (
        .clk(core_clk),
        .rst_n(rst_core_n),
        .count(count_value),
        .compare(cmp_q[i]),
        .act(act_q[FW*i +: FW]),
        .act_wr(wr_emc),
        .act_new(reg_wdata[tmau_pkg::TMAU_ACT_LSB + FW*i +: FW]),
        .evt(evt[i]),
        .level(pin_q[i])
      );
    end
  endgenerate

  // any halting match freezes the counters in this very cycle
  assign halt_now = |(evt & halt_en);
  assign clear_now = (|(evt & clr_en)) & ~halt_now;
  assign run_eff = run_q & ~halt_now;
  assign match_pin_out = pin_q;

  // ------------------------------------------------------------------
  // counters
  // ------------------------------------------------------------------
  tmau_counter u_cnt (
    .clk(core_clk),
    .rst_n(rst_core_n),
    .run(run_eff),
    .hold(hold_q),
    .limit(limit_q),
    .clear(clear_now),
    .load(wr_count),
    .load_val(reg_wdata),
    .count(count_value),
    .presc(presc_q)
  );

  // ------------------------------------------------------------------
  // interrupts
  // ------------------------------------------------------------------
  logic [NCH-1:0] int_st_q;
  logic [NCH-1:0] int_msk_q;
  logic [NCH-1:0] st_clr;
  assign st_clr = wr_st ? reg_wdata[NCH-1:0] : tmau_pkg::TMAU_CH_RST;
  // sticky status, a new event wins over a same-cycle clear
  always_ff @(posedge core_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      int_st_q <= tmau_pkg::TMAU_CH_RST;
    end else begin
      int_st_q <= (int_st_q & ~st_clr) | evt;
    end
  end
  // interrupt enable mask
  always_ff @(posedge core_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      int_msk_q <= tmau_pkg::TMAU_CH_RST;
    end else if (wr_msk) begin
      int_msk_q <= reg_wdata[NCH-1:0];
    end
  end
  assign irq = |(int_st_q & int_msk_q);

  // ------------------------------------------------------------------
  // read path
  // ------------------------------------------------------------------
  logic [31:0] rd_mux;
  logic [NCH-1:0] rd_cmp;
  logic [31:0] rdata_q;
  assign rd_cmp = cmp_sel(reg_addr);
  // unmapped addresses read zero
  always_comb begin
    rd_mux = tmau_pkg::TMAU_WORD_RST;
    case (reg_addr)
      tmau_pkg::TMAU_A_RUN: rd_mux = 32'({hold_q, run_q});
      tmau_pkg::TMAU_A_COUNT: rd_mux = count_value;
      tmau_pkg::TMAU_A_LIMIT: rd_mux = limit_q;
      tmau_pkg::TMAU_A_MAC: rd_mux = 32'(mac_q);
      tmau_pkg::TMAU_A_EMC: rd_mux = 32'({act_q, pin_q});
      tmau_pkg::TMAU_A_INT_ST: rd_mux = 32'(int_st_q);
      tmau_pkg::TMAU_A_INT_MSK: rd_mux = 32'(int_msk_q);
      default: begin
        for (int k = 0; k < NCH; k++) begin
          if (rd_cmp[k]) begin
            rd_mux = cmp_q[k];
          end
        end
      end
    endcase
  end
  // data stand only in the cycle after the read strobe
  always_ff @(posedge core_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      rdata_q <= tmau_pkg::TMAU_WORD_RST;
    end else begin
      rdata_q <= reg_rd ? rd_mux : tmau_pkg::TMAU_WORD_RST;
    end
  end
  assign reg_rdata = rdata_q;

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  // all checks run on the timer clock and sleep while the core reset copy is low
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_core_n);

  halt_freeze_a: assert property (
    halt_now && !hold_q && !wr_count |=> !run_q && count_value == $past(count_value))
    else $error("halting match did not freeze the count");
  halt_keep_a: assert property (
    halt_now && !hold_q && !wr_count && !wr_run |=> ##1 $stable(count_value))
    else $error("halted count moved");
  clear_zero_a: assert property (
    clear_now && !hold_q |=> count_value == tmau_pkg::TMAU_WORD_RST)
    else $error("clear on match did not restart at zero");
  halt_over_clear_a: assert property (
    (|(evt & halt_en & clr_en)) && !hold_q && !wr_count |=> $stable(count_value))
    else $error("clear applied although halt was set");
  keep_count_a: assert property (
    (|evt) && !halt_now && !clear_now && run_q && !hold_q && !wr_count && presc_q == limit_q
    |=> count_value == $past(count_value) + 32'h0000_0001)
    else $error("count did not continue through match");
  match_irq_a: assert property (
    evt[0] && int_msk_q[0] |=> irq)
    else $error("enabled match raised no interrupt");
  reserved_zero_a: assert property (
    reg_rd && reg_addr == tmau_pkg::TMAU_A_MAC |=> (reg_rdata >> tmau_pkg::TMAU_MAC_W) == 0)
    else $error("reserved action bits read nonzero");
  pin_low_a: assert property (
    evt[0] && !wr_emc && act_q[FW-1:0] == tmau_pkg::TMAU_PIN_LOW |=> !match_pin_out[0])
    else $error("low action left pin high");
  pin_toggle_a: assert property (
    evt[1] && !wr_emc && act_q[FW +: FW] == tmau_pkg::TMAU_PIN_TOGGLE
    |=> match_pin_out[1] != $past(match_pin_out[1]))
    else $error("toggle action did not invert pin");
  pin_write_a: assert property (
    wr_emc && reg_wdata[tmau_pkg::TMAU_ACT_LSB +: FW] == tmau_pkg::TMAU_PIN_HIGH |=> match_pin_out[0])
    else $error("action write did not set pin");
  level_read_a: assert property (
    reg_rd && reg_addr == tmau_pkg::TMAU_A_EMC |=> reg_rdata[NCH-1:0] == $past(match_pin_out))
    else $error("pin level readback wrong");
  prescale_a: assert property (
    run_eff && !hold_q && !clear_now && !wr_count && presc_q != limit_q |=> $stable(count_value))
    else $error("count stepped before prescale period");
  run_off_a: assert property (
    !run_q && !hold_q && !clear_now && !wr_count |=> $stable(count_value) && $stable(presc_q))
    else $error("counters moved while stopped");
  // a held equality must stay silent, including the one met at reset
  match_once_a: assert property (
    count_value == cmp_q[0] && $stable(count_value) && $stable(cmp_q[0]) |-> !evt[0])
    else $error("one equality fired twice");

  // clear must zero the prescaler too, or the first period after restart is short
  clear_presc_a: assert property (
    clear_now && !hold_q |=> presc_q == tmau_pkg::TMAU_WORD_RST)
    else $error("clear on match left prescaler running");
  // every match latches its status bit, mask or not
  status_set_a: assert property (
    (|evt) |=> (int_st_q & $past(evt)) == $past(evt))
    else $error("match did not set its status bit");
  // compare registers take the whole written word
  cmp_write_a: assert property (
    wr_cmp[2] |=> cmp_q[2] == $past(reg_wdata))
    else $error("compare write lost bits");
  // a pin moves only on its own match or on a software write
  pin_hold_a: assert property (
    !evt[3] && !wr_emc |=> $stable(match_pin_out[3]))
    else $error("pin changed without match or write");
  // read data idle at zero so stale values never leak
  rdata_idle_a: assert property (
    !reg_rd |=> reg_rdata == tmau_pkg::TMAU_WORD_RST)
    else $error("read data not zero outside a read");

  // main scenarios the bench is expected to reach

  halt_seen_c: cover property (halt_now ##1 !run_q);
  clear_seen_c: cover property (clear_now ##1 count_value == tmau_pkg::TMAU_WORD_RST);
  irq_seen_c: cover property (!irq ##1 irq);
  toggle_seen_c: cover property (evt[1] && act_q[FW +: FW] == tmau_pkg::TMAU_PIN_TOGGLE);
  pin_low_seen_c: cover property (evt[0] && act_q[FW-1:0] == tmau_pkg::TMAU_PIN_LOW);
endmodule : tmau_top

// ==== testbench/tmau_top_tb_top.sv ====
// tmau_top_tb_top: self-checking bench for the match-action timer
// assumes: design files under logic/ compiled first, package tmau_pkg visible
module tmau_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // clock, reset and design
  // ----------------------------------------------------------------
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] reg_addr = 32'h0000_0000;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [3:0] match_pin_out;
  logic irq;
  int miscompares = 0;
  int checks = 0;
  int cycles = 0;
  logic [31:0] rv;
  logic [3:0] pins_exp = 4'h0;

  tmau_top u_tmau_top (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .match_pin_out(match_pin_out),
    .irq(irq)
  );

  // 25 MHz timer clock
  initial begin
    forever #20 core_clk = ~core_clk;
  end

  // hang guard: whole run needs well under this many cycles
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      miscompares = miscompares + 1;
      end_sim();
    end
  end
  // ----------------------------------------------------------------
  // bus cycles and compares
  // ----------------------------------------------------------------
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_bit(input logic got, input logic exp);
    checks = checks + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit

  task automatic end_sim();
    if (miscompares == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim

  // stop, zero the count, park compares far away, clear actions and status
  task automatic reinit();
    wr(tmau_pkg::TMAU_A_RUN, 32'h0000_0002);
    wr(tmau_pkg::TMAU_A_RUN, 32'h0000_0000);
    for (int i = 0; i < 4; i++) begin
      wr(tmau_pkg::TMAU_A_CMP + i * tmau_pkg::TMAU_A_STEP, 32'hFFFF_FFFF);
    end
    wr(tmau_pkg::TMAU_A_MAC, 32'h0000_0000);
    wr(tmau_pkg::TMAU_A_INT_ST, 32'h0000_000F);
    wr(tmau_pkg::TMAU_A_INT_MSK, 32'h0000_0000);
    wr(tmau_pkg::TMAU_A_LIMIT, 32'h0000_0000);
  endtask : reinit
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_and_reserved();
    rd(tmau_pkg::TMAU_A_MAC, rv);
    chk_word(rv, 32'h0000_0000);
    rd(tmau_pkg::TMAU_A_EMC, rv);
    chk_word(rv, 32'h0000_0000);
    chk_word({28'h0, match_pin_out}, 32'h0000_0000);
    wr(tmau_pkg::TMAU_A_MAC, 32'hFFFF_FFFF);
    rd(tmau_pkg::TMAU_A_MAC, rv);
    chk_word(rv, 32'h0000_00FF);
    wr(tmau_pkg::TMAU_A_MAC, 32'h0000_0000);
    wr(tmau_pkg::TMAU_A_CMP + 2 * tmau_pkg::TMAU_A_STEP, 32'hA5C3_0F96);
    rd(tmau_pkg::TMAU_A_CMP + 2 * tmau_pkg::TMAU_A_STEP, rv);
    chk_word(rv, 32'hA5C3_0F96);
    rd(32'hE004_1040, rv);
    chk_word(rv, 32'h0000_0000);
  endtask : t_reset_and_reserved

  // every code on every channel, pin level follows the write at once
  task automatic t_pin_write();
    logic [1:0] seq [5] = '{2'h2, 2'h3, 2'h3, 2'h1, 2'h0};
    for (int ch = 0; ch < 4; ch++) begin
      for (int k = 0; k < 5; k++) begin
        wr(tmau_pkg::TMAU_A_EMC, 32'(seq[k]) << (4 + 2 * ch));
        if (seq[k] == 2'h1) pins_exp[ch] = 1'b0;
        if (seq[k] == 2'h2) pins_exp[ch] = 1'b1;
        if (seq[k] == 2'h3) pins_exp[ch] = ~pins_exp[ch];
        @(posedge core_clk);
        #1;
        chk_word({28'h0, match_pin_out}, {28'h0, pins_exp});
        rd(tmau_pkg::TMAU_A_EMC, rv);
        chk_word(rv, (32'(seq[k]) << (4 + 2 * ch)) | 32'(pins_exp));
      end
    end
  endtask : t_pin_write

  // halt on channel 0, pin toggles, interrupt masked then enabled
  task automatic t_halt_irq();
    reinit();
    wr(tmau_pkg::TMAU_A_CMP, 32'h0000_0003);
    wr(tmau_pkg::TMAU_A_MAC, 32'h0000_0002);
    wr(tmau_pkg::TMAU_A_EMC, 32'h0000_0030);
    @(posedge core_clk);
    #1;
    chk_bit(match_pin_out[0], 1'b1);
    wr(tmau_pkg::TMAU_A_RUN, 32'h0000_0001);
    repeat (12) @(posedge core_clk);
    rd(tmau_pkg::TMAU_A_COUNT, rv);
    chk_word(rv, 32'h0000_0003);
    repeat (5) @(posedge core_clk);
    rd(tmau_pkg::TMAU_A_COUNT, rv);
    chk_word(rv, 32'h0000_0003);
    chk_bit(match_pin_out[0], 1'b0);
    rd(tmau_pkg::TMAU_A_INT_ST, rv);
    chk_word(rv, 32'h0000_0001);
    chk_bit(irq, 1'b0);
    wr(tmau_pkg::TMAU_A_INT_MSK, 32'h0000_0001);
    @(posedge core_clk);
    #1;
    chk_bit(irq, 1'b1);
    wr(tmau_pkg::TMAU_A_INT_ST, 32'h0000_0001);
    @(posedge core_clk);
    #1;
    chk_bit(irq, 1'b0);
  endtask : t_halt_irq

  // clear on channel 1 wraps the count, then halt wins over clear
  task automatic t_clear_and_priority();
    reinit();
    wr(tmau_pkg::TMAU_A_CMP + tmau_pkg::TMAU_A_STEP, 32'h0000_0005);
    wr(tmau_pkg::TMAU_A_MAC, 32'h0000_0004);
    wr(tmau_pkg::TMAU_A_EMC, 32'h0000_00C0);
    wr(tmau_pkg::TMAU_A_RUN, 32'h0000_0001);
    for (int k = 0; k < 8; k++) begin
      rd(tmau_pkg::TMAU_A_COUNT, rv);
      chk_bit(rv <= 32'h0000_0005, 1'b1);
    end
    rd(tmau_pkg::TMAU_A_INT_ST, rv);
    chk_word(rv, 32'h0000_0002);
    wr(tmau_pkg::TMAU_A_MAC, 32'h0000_000C);
    repeat (12) @(posedge core_clk);
    rd(tmau_pkg::TMAU_A_COUNT, rv);
    chk_word(rv, 32'h0000_0005);
  endtask : t_clear_and_priority

  // no halt or clear: counting goes on past the match, status still set
  task automatic t_pass_through();
    reinit();
    wr(tmau_pkg::TMAU_A_CMP + 2 * tmau_pkg::TMAU_A_STEP, 32'h0000_0002);
    wr(tmau_pkg::TMAU_A_CMP, 32'h0000_0001);
    wr(tmau_pkg::TMAU_A_EMC, 32'h0000_0010);
    wr(tmau_pkg::TMAU_A_INT_MSK, 32'h0000_0001);
    wr(tmau_pkg::TMAU_A_RUN, 32'h0000_0001);
    repeat (10) @(posedge core_clk);
    rd(tmau_pkg::TMAU_A_COUNT, rv);
    chk_bit(rv > 32'h0000_0005, 1'b1);
    rd(tmau_pkg::TMAU_A_INT_ST, rv);
    chk_word(rv, 32'h0000_0005);
    chk_bit(match_pin_out[0], 1'b0);
    chk_bit(irq, 1'b1);
  endtask : t_pass_through

  // limit 3: one step per 4 cycles, 42 running edges give 10; stopped count stays put
  task automatic t_prescale_run();
    logic [31:0] again;
    reinit();
    wr(tmau_pkg::TMAU_A_LIMIT, 32'h0000_0003);
    wr(tmau_pkg::TMAU_A_RUN, 32'h0000_0001);
    repeat (40) @(posedge core_clk);
    wr(tmau_pkg::TMAU_A_RUN, 32'h0000_0000);
    rd(tmau_pkg::TMAU_A_COUNT, rv);
    chk_word(rv, 32'h0000_000A);
    repeat (20) @(posedge core_clk);
    rd(tmau_pkg::TMAU_A_COUNT, again);
    chk_word(again, rv);
  endtask : t_prescale_run

  // count holds the compare value for 16 cycles; only one event
  task automatic t_single_event();
    reinit();
    wr(tmau_pkg::TMAU_A_LIMIT, 32'h0000_000F);
    wr(tmau_pkg::TMAU_A_CMP + 3 * tmau_pkg::TMAU_A_STEP, 32'h0000_0001);
    wr(tmau_pkg::TMAU_A_RUN, 32'h0000_0001);
    rv = 32'h0;
    for (int k = 0; k < 30 && rv[3] !== 1'b1; k++) begin
      rd(tmau_pkg::TMAU_A_INT_ST, rv);
    end
    chk_bit(rv[3], 1'b1);
    wr(tmau_pkg::TMAU_A_INT_ST, 32'h0000_0008);
    rd(tmau_pkg::TMAU_A_INT_ST, rv);
    chk_word(rv, 32'h0000_0000);
    rd(tmau_pkg::TMAU_A_COUNT, rv);
    chk_word(rv, 32'h0000_0001);
  endtask : t_single_event
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    t_reset_and_reserved();
    t_pin_write();
    t_halt_irq();
    t_clear_and_priority();
    t_pass_through();
    t_prescale_run();
    t_single_event();
    end_sim();
  end
endmodule : tmau_top_tb_top
